//--- fpp_flash_partition_protection.sv
`timescale 1ns/10ps
`default_nettype none
`include "fpp_params.svh"

// Behaviour
// - Flash split into application, boot, storage regions.
// - Both enables at one: all application.
// - Boot region size from three-bit select.
// - Storage region exists only when enable cleared.
// - Storage region: top 128 words.
// - Storage region never valid for execution.
// - Independent write locks: application, boot, configuration.
// - Locked write: no change, set error flag.
// - Bad fetch: violation reset, clear violation flag.
module fpp_flash_partition_protection #(
  parameter int ADDR_W      = 13,
  parameter int FLASH_WORDS = `FPP_FLASH_WORDS
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic              boot_region_enable_n,
  input  wire logic [2:0]        boot_region_size_select,
  input  wire logic              storage_region_enable_n,
  input  wire logic              app_region_write_lock_n,
  input  wire logic              boot_region_write_lock_n,
  input  wire logic              config_region_write_lock_n,
  input  wire logic              fetch_valid,
  input  wire logic [ADDR_W-1:0] fetch_addr,
  input  wire logic              wr_req,
  input  wire logic              wr_config_space,
  input  wire logic [ADDR_W-1:0] wr_addr,
  output var  logic              wr_accept,
  output var  logic              wr_reject,
  output var  logic              exec_violation_reset,
  output var  fpp_pkg::fpp_irq_t irq_status_out,
  output var  logic              irq
);
  import fpp_pkg::*;

  // Latched configuration.
  logic              cfg_loaded_reg;
  logic              boot_en_n_reg;
  logic [2:0]        boot_size_reg;
  logic              stor_en_n_reg;
  logic              app_lock_n_reg;
  logic              boot_lock_n_reg;
  logic              cfg_lock_n_reg;

  // Software visible state.
  logic              write_error_flag_reg;
  logic              exec_violation_flag_reg;
  fpp_irq_t          irq_status_reg;
  fpp_irq_t          irq_mask_reg;
  logic [ADDR_W-1:0] viol_addr_reg;

  // Bus handshake.
  logic              bus_done;
  logic              bus_wr;
  logic              bus_answer;
  logic              wr_wrctl;
  logic              wr_rststat;
  logic              wr_mask;
  logic              rd_status;
  logic [31:0]       rdata_next;
  logic              addr_hit;
  fpp_apb_e          apb_state_reg;
  fpp_apb_e          apb_state_next;

  // Event decode.
  logic              fetch_bad;
  logic              wr_blocked;
  logic              wr_done_ok;

  // One compare shared by the address check and every register strobe.
  function automatic logic reg_is(input logic [11:0] a, input logic [11:0] ofs);
    reg_is = (a == ofs);
  endfunction

  // Size of the boot region in words, zero when disabled.
  function automatic logic [31:0] boot_words(input logic en_n, input logic [2:0] sel);
    logic [31:0] w;
    w = 32'(`FPP_BOOT_BASE_WORDS) << sel;
    if (w > 32'(FLASH_WORDS)) begin
      w = 32'(FLASH_WORDS);
    end
    boot_words = en_n ? 32'h0 : w;
  endfunction

  // Which region an address falls in, from the latched configuration.
  function automatic fpp_region_e region_of(input logic [ADDR_W-1:0] a);
    logic [31:0] addr32;
    addr32 = 32'(a);
    if (!stor_en_n_reg && addr32 >= 32'(FLASH_WORDS - `FPP_STORAGE_WORDS)) begin
      region_of = FPP_REGION_STOR;
    end else if (addr32 < boot_words(boot_en_n_reg, boot_size_reg)) begin
      region_of = FPP_REGION_BOOT;
    end else begin
      region_of = FPP_REGION_APP;
    end
  endfunction

  // Only addresses inside the flash and outside the storage region may run.
  function automatic logic exec_ok(input logic [ADDR_W-1:0] a);
    exec_ok = (32'(a) < 32'(FLASH_WORDS)) && (region_of(a) != FPP_REGION_STOR);
  endfunction

  // Storage is writable by default; only the three locks exist.
  function automatic logic write_locked(input logic cfg_space, input logic [ADDR_W-1:0] a);
    fpp_region_e r;
    r = region_of(a);
    if (cfg_space) begin
      write_locked = !cfg_lock_n_reg;
    end else if (32'(a) >= 32'(FLASH_WORDS)) begin
      write_locked = 1'b1;
    end else if (r == FPP_REGION_BOOT) begin
      write_locked = !boot_lock_n_reg;
    end else if (r == FPP_REGION_APP) begin
      write_locked = !app_lock_n_reg;
    end else begin
      write_locked = 1'b0;
    end
  endfunction

  // The fuse levels are sampled by a clocked process after reset release, never under the reset itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_loaded_reg <= 1'b0;
    end else begin
      cfg_loaded_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_en_n_reg   <= 1'b1;
      boot_size_reg   <= 3'h0;
      stor_en_n_reg   <= 1'b1;
      app_lock_n_reg  <= 1'b1;
      boot_lock_n_reg <= 1'b1;
      cfg_lock_n_reg  <= 1'b1;
    end else if (!cfg_loaded_reg) begin
      boot_en_n_reg   <= boot_region_enable_n;
      boot_size_reg   <= boot_region_size_select;
      stor_en_n_reg   <= storage_region_enable_n;
      app_lock_n_reg  <= app_region_write_lock_n;
      boot_lock_n_reg <= boot_region_write_lock_n;
      cfg_lock_n_reg  <= config_region_write_lock_n;
    end
  end

  // Requests before the configuration is loaded are not checked; writes are refused then.
  assign fetch_bad  = cfg_loaded_reg && fetch_valid && !exec_ok(fetch_addr);
  assign wr_blocked = wr_req && (!cfg_loaded_reg || write_locked(wr_config_space, wr_addr));
  assign wr_done_ok = wr_req && !wr_blocked;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_accept <= 1'b0;
      wr_reject <= 1'b0;
    end else begin
      wr_accept <= wr_done_ok;
      wr_reject <= wr_blocked;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_violation_reset <= 1'b0;
    end else begin
      exec_violation_reset <= fetch_bad;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      viol_addr_reg <= '0;
    end else if (fetch_bad) begin
      viol_addr_reg <= fetch_addr;
    end
  end

  // APB: one wait state, so the answer and read data come from flops.
  assign bus_done = psel && penable && pready;
  assign bus_wr   = bus_done && pwrite;
  assign addr_hit = reg_is(paddr, `FPP_CFG_OFS) || reg_is(paddr, `FPP_WRCTL_OFS) ||
                    reg_is(paddr, `FPP_RSTSTAT_OFS) || reg_is(paddr, `FPP_IRQ_STATUS_OFS) ||
                    reg_is(paddr, `FPP_IRQ_MASK_OFS) || reg_is(paddr, `FPP_VIOL_ADDR_OFS);

  // The answer state lasts one cycle, so a master that keeps penable high sees a pready pulse every other cycle.
  always_comb begin
    apb_state_next = apb_state_reg;
    case (apb_state_reg)
      FPP_APB_IDLE: begin
        if (psel && penable) begin
          apb_state_next = FPP_APB_ANSWER;
        end
      end
      FPP_APB_ANSWER: begin
        apb_state_next = FPP_APB_IDLE;
      end
      default: begin
        apb_state_next = FPP_APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state_reg <= FPP_APB_IDLE;
    end else begin
      apb_state_reg <= apb_state_next;
    end
  end

  // Writes act at the edge where the master takes pready; the read clear acts when the word is captured,
  // so an event that lands between capture and hand-over stays pending.
  assign bus_answer = (apb_state_next == FPP_APB_ANSWER);
  assign wr_wrctl   = bus_wr && reg_is(paddr, `FPP_WRCTL_OFS);
  assign wr_rststat = bus_wr && reg_is(paddr, `FPP_RSTSTAT_OFS);
  assign wr_mask    = bus_wr && reg_is(paddr, `FPP_IRQ_MASK_OFS);
  assign rd_status  = bus_answer && !pwrite && reg_is(paddr, `FPP_IRQ_STATUS_OFS);

  always_comb begin
    rdata_next = 32'h0;
    case (paddr)
      `FPP_CFG_OFS: begin
        rdata_next[`FPP_CFG_BOOT_EN_N]                               = boot_en_n_reg;
        rdata_next[`FPP_CFG_BOOT_SIZE_LO +: 3]                       = boot_size_reg;
        rdata_next[`FPP_CFG_STOR_EN_N]                               = stor_en_n_reg;
        rdata_next[`FPP_CFG_APP_LOCK_N]                              = app_lock_n_reg;
        rdata_next[`FPP_CFG_BOOT_LOCK_N]                             = boot_lock_n_reg;
        rdata_next[`FPP_CFG_CFG_LOCK_N]                              = cfg_lock_n_reg;
        rdata_next[`FPP_CFG_LOADED]                                  = cfg_loaded_reg;
      end
      `FPP_WRCTL_OFS: begin
        rdata_next[`FPP_WRCTL_ERR] = write_error_flag_reg;
      end
      `FPP_RSTSTAT_OFS: begin
        rdata_next[`FPP_RSTSTAT_VIOL] = exec_violation_flag_reg;
      end
      `FPP_IRQ_STATUS_OFS: begin
        rdata_next[1:0] = irq_status_reg;
      end
      `FPP_IRQ_MASK_OFS: begin
        rdata_next[1:0] = irq_mask_reg;
      end
      `FPP_VIOL_ADDR_OFS: begin
        rdata_next[ADDR_W-1:0] = viol_addr_reg;
      end
      default: begin
        rdata_next = 32'h0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= bus_answer;
    end
  end

  // Read data is zero outside the answer cycle, so a stale word never lingers on the bus.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else begin
      prdata <= (bus_answer && !pwrite) ? rdata_next : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= bus_answer && !addr_hit;
    end
  end

  // Software clears the error by writing zero; a new refusal in the same cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_error_flag_reg <= 1'b0;
    end else if (wr_blocked) begin
      write_error_flag_reg <= 1'b1;
    end else if (wr_wrctl && !pwdata[`FPP_WRCTL_ERR]) begin
      write_error_flag_reg <= 1'b0;
    end
  end

  // Flag reads one until a violation clears it; software writes one to rearm it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_violation_flag_reg <= `FPP_VIOL_FLAG_RST;
    end else if (fetch_bad) begin
      exec_violation_flag_reg <= 1'b0;
    end else if (wr_rststat && pwdata[`FPP_RSTSTAT_VIOL]) begin
      exec_violation_flag_reg <= 1'b1;
    end
  end

  // Read clears the sticky bits, but an event in that same cycle survives.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= 2'h0;
    end else begin
      irq_status_reg <= (rd_status ? 2'h0 : irq_status_reg) |
                        {fetch_bad, wr_blocked};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= `FPP_IRQ_MASK_RST;
    end else if (wr_mask) begin
      irq_mask_reg <= pwdata[1:0];
    end
  end

  // The output follows the status one cycle late; that is the price of driving it from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_out <= 2'h0;
    end else begin
      irq_status_out <= irq_status_reg;
    end
  end

endmodule
`default_nettype wire

//--- fpp_params.svh
`ifndef FPP_PARAMS_SVH
`define FPP_PARAMS_SVH

// Register byte offsets on the APB bus.
`define FPP_CFG_OFS          12'h000
`define FPP_WRCTL_OFS        12'h004
`define FPP_RSTSTAT_OFS      12'h008
`define FPP_IRQ_STATUS_OFS   12'h00c
`define FPP_IRQ_MASK_OFS     12'h010
`define FPP_VIOL_ADDR_OFS    12'h014

// Field positions.
`define FPP_CFG_BOOT_EN_N    0
`define FPP_CFG_BOOT_SIZE_LO 1
`define FPP_CFG_STOR_EN_N    4
`define FPP_CFG_APP_LOCK_N   5
`define FPP_CFG_BOOT_LOCK_N  6
`define FPP_CFG_CFG_LOCK_N   7
`define FPP_CFG_LOADED       8
`define FPP_WRCTL_ERR        0
`define FPP_RSTSTAT_VIOL     0
`define FPP_IRQ_WRITE_ERROR_FLAG        0
`define FPP_IRQ_VIOL         1

// Reset values and sizes.
`define FPP_FLASH_WORDS      8192
`define FPP_STORAGE_WORDS    128
`define FPP_BOOT_BASE_WORDS  512
`define FPP_IRQ_MASK_RST     2'h0
`define FPP_VIOL_FLAG_RST    1'h1

`endif

//--- fpp_pkg.sv
package fpp_pkg;

  typedef enum logic [2:0] {
    FPP_REGION_APP  = 3'b001,
    FPP_REGION_BOOT = 3'b010,
    FPP_REGION_STOR = 3'b100
  } fpp_region_e;

  typedef logic [1:0] fpp_irq_t;

  typedef enum logic [1:0] {
    FPP_APB_IDLE   = 2'b01,
    FPP_APB_ANSWER = 2'b10
  } fpp_apb_e;

endpackage

//--- fpp_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module fpp_core_model #(
  parameter int ADDR_W = 13
) (
  input  wire logic              pclk,
  output var  logic              fetch_valid,
  output var  logic [ADDR_W-1:0] fetch_addr,
  output var  logic              wr_req,
  output var  logic              wr_config_space,
  output var  logic [ADDR_W-1:0] wr_addr
);
  // Idle address lines show the inverse of the last one, so a stale address never looks valid.
  initial begin
    fetch_valid = 1'b0;
    fetch_addr = '0;
    wr_req = 1'b0;
    wr_config_space = 1'b0;
    wr_addr = '0;
  end
  task automatic fetch(input logic [ADDR_W-1:0] a);
    @(posedge pclk);
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    @(posedge pclk);
    fetch_valid <= 1'b0;
    fetch_addr <= ~a;
  endtask
  task automatic write(input logic [ADDR_W-1:0] a, input logic c);
    @(posedge pclk);
    wr_req <= 1'b1;
    wr_config_space <= c;
    wr_addr <= a;
    @(posedge pclk);
    wr_req <= 1'b0;
    wr_config_space <= ~c;
    wr_addr <= ~a;
  endtask
endmodule
`default_nettype wire

//--- fpp_flash_partition_protection_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module fpp_flash_partition_protection_assertions #(
  parameter int ADDR_W = 13
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              boot_region_enable_n,
  input wire logic [2:0]        boot_region_size_select,
  input wire logic              storage_region_enable_n,
  input wire logic              app_region_write_lock_n,
  input wire logic              boot_region_write_lock_n,
  input wire logic              config_region_write_lock_n,
  input wire logic              fetch_valid,
  input wire logic [ADDR_W-1:0] fetch_addr,
  input wire logic              wr_req,
  input wire logic              wr_config_space,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic              wr_accept,
  input wire logic              wr_reject,
  input wire logic              exec_violation_reset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic up_reg, in_boot, in_stor, known, exp_rej;
  // Fuses load at the first edge after reset, so the lock and storage checks skip requests before that.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) up_reg <= 1'b0;
    else up_reg <= 1'b1;
  assign in_boot = !boot_region_enable_n && wr_addr < (32'h200 << boot_region_size_select);
  assign in_stor = !storage_region_enable_n && wr_addr >= 13'h1f80;
  assign known = wr_config_space || !(in_boot && in_stor);
  assign exp_rej = wr_config_space ? !config_region_write_lock_n :
                   in_boot ? !boot_region_write_lock_n : !in_stor && !app_region_write_lock_n;
  sequence apb_setup_s;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence wr_check_s;
    wr_req && up_reg && known;
  endsequence
  apb_wait_a: assert property (apb_setup_s |=> pready ##1 !pready)
    else $error("pready timing wrong");
  wr_one_answer_a: assert property (wr_req |=> wr_accept != wr_reject)
    else $error("write answer not single");
  wr_idle_quiet_a: assert property (!wr_req |=> !wr_accept && !wr_reject)
    else $error("write answer without request");
  wr_locked_a: assert property ((wr_check_s and exp_rej) |=> wr_reject)
    else $error("locked write not refused");
  wr_open_a: assert property ((wr_check_s and !exp_rej) |=> wr_accept)
    else $error("open write refused");
  stor_fetch_a: assert property (fetch_valid && up_reg && !storage_region_enable_n && fetch_addr >= 13'h1f80
    |=> exec_violation_reset)
    else $error("storage fetch not caught");
  plain_fetch_a: assert property (fetch_valid && (storage_region_enable_n || fetch_addr < 13'h1f80)
    |=> !exec_violation_reset)
    else $error("valid fetch caught");
  viol_cause_a: assert property (!fetch_valid |=> !exec_violation_reset)
    else $error("violation without fetch");
endmodule
bind fpp_flash_partition_protection fpp_flash_partition_protection_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .boot_region_enable_n(boot_region_enable_n), .boot_region_size_select(boot_region_size_select),
  .storage_region_enable_n(storage_region_enable_n), .app_region_write_lock_n(app_region_write_lock_n),
  .boot_region_write_lock_n(boot_region_write_lock_n), .config_region_write_lock_n(config_region_write_lock_n),
  .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .wr_req(wr_req), .wr_config_space(wr_config_space),
  .wr_addr(wr_addr), .wr_accept(wr_accept), .wr_reject(wr_reject), .exec_violation_reset(exec_violation_reset)
);
`default_nettype wire

//--- tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import fpp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slv_err;
  logic        boot_region_enable_n, storage_region_enable_n, app_region_write_lock_n;
  logic        boot_region_write_lock_n, config_region_write_lock_n, wr_accept, wr_reject;
  logic        fetch_valid, wr_req, wr_config_space, exec_violation_reset;
  logic [2:0]  boot_region_size_select;
  logic [11:0] paddr;
  logic [12:0] fetch_addr, wr_addr;
  logic [31:0] pwdata, prdata, rd;
  fpp_irq_t    irq_status_out;
  int          error_cnt, total_checks;
  fpp_flash_partition_protection dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_region_enable_n(boot_region_enable_n), .boot_region_size_select(boot_region_size_select),
    .storage_region_enable_n(storage_region_enable_n), .app_region_write_lock_n(app_region_write_lock_n),
    .boot_region_write_lock_n(boot_region_write_lock_n), .config_region_write_lock_n(config_region_write_lock_n),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .wr_req(wr_req), .wr_config_space(wr_config_space),
    .wr_addr(wr_addr), .wr_accept(wr_accept), .wr_reject(wr_reject), .exec_violation_reset(exec_violation_reset),
    .irq_status_out(irq_status_out), .irq(irq)
  );
  fpp_core_model core (
    .pclk(pclk), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .wr_req(wr_req),
    .wr_config_space(wr_config_space), .wr_addr(wr_addr)
  );
  always #5 pclk = ~pclk;
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic rst(input logic [7:0] f);
    @(posedge pclk);
    presetn <= 1'b0;
    {config_region_write_lock_n, boot_region_write_lock_n, app_region_write_lock_n,
     storage_region_enable_n, boot_region_size_select, boot_region_enable_n} <= f;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      report_and_stop;
    end
    rd = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic wt(input logic [12:0] a, input logic c, input logic e);
    core.write(a, c);
    #1 chk("reject", wr_reject, e);
    chk("accept", wr_accept, !e);
  endtask
  task automatic ft(input logic [12:0] a, input logic e);
    core.fetch(a);
    #1 chk("violation", exec_violation_reset, e);
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    {config_region_write_lock_n, boot_region_write_lock_n, app_region_write_lock_n,
     storage_region_enable_n, boot_region_size_select, boot_region_enable_n} = 8'hff;
    error_cnt = 0;
    total_checks = 0;
    rst(8'hff);
    rdchk(12'h000, 32'h1ff, "cfg");
    chk("slverr", slv_err, 1'b0);
    wt(13'h1fa4, 1'b0, 1'b0);
    ft(13'h1fff, 1'b0);
    rst(8'hc2);
    rdchk(12'h008, 32'h1, "flag");
    wt(13'h3ff, 1'b0, 1'b0);
    wt(13'h400, 1'b0, 1'b1);
    wt(13'h0, 1'b1, 1'b0);
    wt(13'h1f80, 1'b0, 1'b0);
    rdchk(12'h004, 32'h1, "write_error_flag");
    apb(1'b1, 12'h004, 32'h0);
    rdchk(12'h004, 32'h0, "write_error_flag");
    ft(13'h1f7f, 1'b0);
    ft(13'h1f80, 1'b1);
    rdchk(12'h008, 32'h0, "flag");
    rdchk(12'h014, 32'h1f80, "viol_addr");
    #1 chk("irq", irq, 1'b0);
    rdchk(12'h00c, 32'h3, "status");
    rdchk(12'h00c, 32'h0, "status");
    apb(1'b1, 12'h008, 32'h1);
    rdchk(12'h008, 32'h1, "flag");
    apb(1'b1, 12'h010, 32'h2);
    ft(13'h1fff, 1'b1);
    repeat (2) @(posedge pclk);
    #1 chk("irq", irq, 1'b1);
    chk("status_out", irq_status_out, 32'h2);
    rdchk(12'h00c, 32'h2, "status");
    repeat (2) @(posedge pclk);
    #1 chk("irq", irq, 1'b0);
    chk("status_out", irq_status_out, 32'h0);
    rdchk(12'h020, 32'h0, "unmapped");
    chk("slverr", slv_err, 1'b1);
    rst(8'h30);
    wt(13'h1ff, 1'b0, 1'b1);
    wt(13'h200, 1'b0, 1'b0);
    wt(13'h5, 1'b1, 1'b1);
    wt(13'h1fff, 1'b0, 1'b0);
    ft(13'h1fff, 1'b0);
    rst(8'hbe);
    rdchk(12'h000, 32'h1be, "cfg");
    wt(13'h1fff, 1'b0, 1'b1);
    report_and_stop;
  end
endmodule
`default_nettype wire
